// [design/cicr_pkg.sv]
/*
 * Shared constants and types for the charger input/control register pair.
 * Assumes one 10 MHz clock and an I2C host on open-drain pins.
 */
`default_nettype none

package cicr_pkg;

    // ****************************************
    // bus and map
    // ****************************************
    localparam logic [6:0] CICR_DEV_ADDR    = 7'h6a;
    localparam logic [7:0] CICR_INPUT_OFS   = 8'h00;
    localparam logic [7:0] CICR_CTRL_OFS    = 8'h01;
    localparam logic [7:0] CICR_LAST_OFS    = 8'h0c;
    localparam logic [7:0] CICR_UNMAPPED_RD = 8'hff;
    localparam logic [3:0] CICR_BYTE_BITS   = 4'h8;

    // ****************************************
    // register layouts and reset values
    // ****************************************
    typedef struct packed {
        logic       hiz_en;
        logic       therm_ignore;
        logic       sense_disable;
        logic [4:0] ilim_code;
    } cicr_input_reg_t;

    typedef struct packed {
        logic       pfm_disable;
        logic       wd_kick;
        logic       boost_en;
        logic       charge_en;
        logic [2:0] system_min_voltage;
        logic       boost_low_sel;
    } cicr_ctrl_reg_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } cicr_wr_t;

    localparam cicr_input_reg_t CICR_INPUT_RST = 8'h17;
    localparam cicr_ctrl_reg_t  CICR_CTRL_RST  = 8'h1a;

    // ****************************************
    // analog settings in mA and mV
    // ****************************************
    localparam logic [4:0]  CICR_ILIM_PSEL_HI  = 5'h04;
    localparam logic [4:0]  CICR_ILIM_PSEL_LO  = 5'h17;
    localparam logic [11:0] CICR_ILIM_STEP_MV  = 12'h064;
    localparam logic [11:0] CICR_ILIM_OFS_MV   = 12'h064;
    localparam logic [11:0] CICR_BST_EXIT_HI   = 12'haf0;
    localparam logic [11:0] CICR_BST_START_HI  = 12'hbb8;
    localparam logic [11:0] CICR_BST_EXIT_LO   = 12'h9c4;
    localparam logic [11:0] CICR_BST_START_LO  = 12'haf0;
    localparam logic [11:0] CICR_SYSTEM_MIN_VOLTAGE_MV [8] = '{
        12'ha28, 12'haf0, 12'hbb8, 12'hc80,
        12'hd48, 12'hdac, 12'he10, 12'he74
    };

endpackage

`default_nettype wire

// [design/cicr_i2c_slave.sv]
/*
 * I2C slave front end: address match, register pointer with auto
 * increment, write strobes and read byte shifting.
 * Assumes scl and sda are already synchronous to the clock; no stretching.
 */
`timescale 1ns/1ps
`default_nettype none

module cicr_i2c_slave
    import cicr_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe_out,
    output logic [7:0]      rd_addr_out,
    input  wire logic [7:0] rd_data_in,
    output cicr_wr_t        wr_out
);

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_REG  = 7'b0000100,
        ST_WR   = 7'b0001000,
        ST_RD   = 7'b0010000,
        ST_ACK  = 7'b0100000,
        ST_RACK = 7'b1000000
    } cicr_i2c_st_t;

    cicr_i2c_st_t st_q;
    cicr_i2c_st_t nxt_q;
    logic [7:0]   sh_q;
    logic [3:0]   cnt_q;
    logic [7:0]   ptr_q;
    logic         drv_q;
    logic         scl_q;
    logic         sda_q;
    cicr_wr_t     wr_q;

    wire scl_rise  = scl_in & ~scl_q;
    wire scl_fall  = ~scl_in & scl_q;
    wire start_det = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_det  = scl_in & scl_q & ~sda_q & sda_in;
    wire byte_done = scl_fall && (cnt_q == CICR_BYTE_BITS);
    wire addr_hit  = (sh_q[7:1] == CICR_DEV_ADDR);
    wire ptr_ok    = (ptr_q <= CICR_LAST_OFS);

    assign sda_oe_out  = drv_q;
    assign rd_addr_out = ptr_q;
    assign wr_out      = wr_q;

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_q  <= ST_IDLE;
            nxt_q <= ST_IDLE;
            sh_q  <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            drv_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            wr_q  <= '0;
        end
        else
        begin
            scl_q    <= scl_in;
            sda_q    <= sda_in;
            wr_q.valid <= 1'b0;
            if (start_det)
            begin
                st_q  <= ST_ADDR;
                cnt_q <= 4'h0;
                drv_q <= 1'b0;
            end
            else if (stop_det)
            begin
                st_q  <= ST_IDLE;
                drv_q <= 1'b0;
            end
            else
            begin
                case (st_q)
                    ST_ADDR, ST_REG, ST_WR:
                    begin
                        if (scl_rise)
                        begin
                            sh_q  <= {sh_q[6:0], sda_in};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        if (byte_done)
                        begin
                            cnt_q <= 4'h0;
                            st_q  <= ST_IDLE;
                            if (st_q == ST_ADDR && addr_hit)
                            begin
                                drv_q <= 1'b1;
                                st_q  <= ST_ACK;
                                nxt_q <= sh_q[0] ? ST_RD : ST_REG;
                            end
                            else if (st_q == ST_REG && sh_q <= CICR_LAST_OFS)
                            begin
                                drv_q <= 1'b1;
                                ptr_q <= sh_q;
                                st_q  <= ST_ACK;
                                nxt_q <= ST_WR;
                            end
                            else if (st_q == ST_WR && ptr_ok)
                            begin
                                wr_q  <= '{valid: 1'b1, addr: ptr_q, data: sh_q};
                                drv_q <= 1'b1;
                                ptr_q <= ptr_q + 8'h01;
                                st_q  <= ST_ACK;
                                nxt_q <= ST_WR;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            drv_q <= 1'b0;
                            st_q  <= nxt_q;
                            cnt_q <= 4'h0;
                            if (nxt_q == ST_RD)
                            begin
                                sh_q  <= rd_data_in;
                                drv_q <= ~rd_data_in[7];
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    ST_RD:
                    begin
                        if (scl_fall)
                        begin
                            cnt_q <= cnt_q + 4'h1;
                            sh_q  <= {sh_q[6:0], 1'b0};
                            drv_q <= ~sh_q[6];
                            if (cnt_q == 4'h7)
                            begin
                                drv_q <= 1'b0;
                                st_q  <= ST_RACK;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        // host nack ends the read, ack fetches the next byte
                        if (scl_rise)
                        begin
                            st_q  <= sda_in ? ST_IDLE : ST_ACK;
                            nxt_q <= ST_RD;
                        end
                    end
                    default:
                    begin
                        drv_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    chk_stop_releases_sda:
    assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        stop_det |=> !sda_oe_out)
    else $error("sda still driven after stop");

endmodule

`default_nettype wire

// [design/cicr_regs.sv]
/*
 * Input current limit and charger control registers with the charge and
 * boost gating that hangs off them, reached over I2C.
 * Assumes register reset, watchdog expiry and source detection done
 * arrive as one-cycle pulses from the rest of the charger.
 */
// Summary of operation
// - input register bit 7 puts the input in high impedance, cleared by reset.
// - input bit 6 set treats the thermistor as good and reports fault status 000.
// - input bit 5 clear regulates on the remote sense pin unless it failed; set uses the battery pin.
// - input bits 4:0 are a binary current limit of 100 mA per step plus 100 mA, default 10111.
// - at the end of source detection the limit becomes 500 mA with select high, 2.4 A with it low.
// - control bit 7 set disables pulse frequency modulation in buck and boost.
// - a written 1 in control bit 6 restarts the watchdog and then clears itself.
// - control bit 5 enables boost; with charge also enabled the mode follows the adapter.
// - charging needs the charge pin low, control bit 4 set and a nonzero charge current.
// - control bits 3:1 select the minimum system voltage from 2.6 V to 3.7 V, default 101.
// - control bit 0 selects boost battery thresholds 2.8/3.0 V or 2.5/2.8 V.
// - any host write moves the charger from default mode to host mode.
`timescale 1ns/1ps
`default_nettype none

module cicr_regs
    import cicr_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    input  wire logic        reg_reset_in,
    input  wire logic        wdt_expired_in,
    input  wire logic        src_detect_done_in,
    input  wire logic        source_select_in,
    input  wire logic        charge_pin_n_in,
    input  wire logic        chg_current_nonzero_in,
    input  wire logic        adapter_present_in,
    input  wire logic        thermistor_good_in,
    input  wire logic [2:0]  thermistor_fault_in,
    input  wire logic        remote_sense_fail_status_in,
    output logic             high_impedance_input_enable_out,
    output logic             pulse_freq_mode_disable_out,
    output logic             regulate_on_bat_pin_out,
    output logic [4:0]       input_current_limit_code_out,
    output logic [11:0]      input_current_limit_ma_out,
    output logic [2:0]       system_min_voltage_out,
    output logic [11:0]      system_min_mv_out,
    output logic [11:0]      boost_exit_mv_out,
    output logic [11:0]      boost_start_mv_out,
    output logic [2:0]       thermistor_fault_status_out,
    output logic             watchdog_restart_out,
    output logic             host_mode_out,
    output logic             charge_active_out,
    output logic             boost_active_out
);

    // ****************************************
    // register state
    // ****************************************
    cicr_input_reg_t in_q;
    cicr_input_reg_t in_d;
    cicr_ctrl_reg_t  ctl_q;
    cicr_ctrl_reg_t  ctl_d;
    logic            host_mode_q;
    logic            host_mode_d;
    logic [7:0]      rd_addr;
    logic [7:0]      rd_data;
    cicr_wr_t        wr;

    // ****************************************
    // bus front end
    // ****************************************
    cicr_i2c_slave cicr_i2c_slave_i (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_oe_out (sda_oe_out),
        .rd_addr_out(rd_addr),
        .rd_data_in (rd_data),
        .wr_out     (wr)
    );

    // open drain: only ever pulls low
    assign sda_out = 1'b0;

    wire wr_input = wr.valid && (wr.addr == CICR_INPUT_OFS);
    wire wr_ctrl  = wr.valid && (wr.addr == CICR_CTRL_OFS);
    wire kick_wr  = wr_ctrl && wr.data[6];

    // live values, so automatic code loads are visible to the host
    assign rd_data = (rd_addr == CICR_INPUT_OFS) ? in_q :
                     (rd_addr == CICR_CTRL_OFS)  ? ctl_q :
                     CICR_UNMAPPED_RD;

    // ****************************************
    // next register values
    // ****************************************
    always_comb
    begin
        in_d        = in_q;
        ctl_d       = ctl_q;
        host_mode_d = host_mode_q;
        if (ctl_q.wd_kick)
        begin
            ctl_d.wd_kick = 1'b0;
        end
        if (src_detect_done_in)
        begin
            in_d.ilim_code = source_select_in ? CICR_ILIM_PSEL_HI
                                              : CICR_ILIM_PSEL_LO;
        end
        if (wdt_expired_in)
        begin
            in_d.hiz_en     = CICR_INPUT_RST.hiz_en;
            ctl_d.wd_kick   = CICR_CTRL_RST.wd_kick;
            ctl_d.boost_en  = CICR_CTRL_RST.boost_en;
            ctl_d.charge_en = CICR_CTRL_RST.charge_en;
            host_mode_d     = 1'b0;
        end
        // a host write lands after the automatic updates so it wins
        if (wr_input)
        begin
            in_d = wr.data;
        end
        if (wr_ctrl)
        begin
            ctl_d = wr.data;
        end
        if (wr.valid)
        begin
            host_mode_d = 1'b1;
        end
        if (reg_reset_in)
        begin
            in_d        = CICR_INPUT_RST;
            ctl_d       = CICR_CTRL_RST;
            host_mode_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            in_q        <= CICR_INPUT_RST;
            ctl_q       <= CICR_CTRL_RST;
            host_mode_q <= 1'b0;
        end
        else
        begin
            in_q        <= in_d;
            ctl_q       <= ctl_d;
            host_mode_q <= host_mode_d;
        end
    end

    // ****************************************
    // derived controls
    // ****************************************
    wire therm_ok   = in_q.therm_ignore | thermistor_good_in;
    wire charge_ok  = ~charge_pin_n_in & ctl_q.charge_en
                      & chg_current_nonzero_in;
    // charge on adapter, boost without it: the handover needs both bits set
    wire charge_go  = charge_ok & therm_ok & adapter_present_in
                      & ~in_q.hiz_en;
    wire boost_go   = ctl_q.boost_en & therm_ok & ~adapter_present_in;
    wire [11:0] ilim_ma = 12'(in_q.ilim_code) * CICR_ILIM_STEP_MV
                          + CICR_ILIM_OFS_MV;

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            high_impedance_input_enable_out <= 1'b0;
            pulse_freq_mode_disable_out     <= 1'b0;
            regulate_on_bat_pin_out         <= 1'b0;
            input_current_limit_code_out    <= CICR_INPUT_RST.ilim_code;
            input_current_limit_ma_out      <= 12'h000;
            system_min_voltage_out          <= CICR_CTRL_RST.system_min_voltage;
            system_min_mv_out               <= 12'h000;
            boost_exit_mv_out               <= 12'h000;
            boost_start_mv_out              <= 12'h000;
            thermistor_fault_status_out     <= 3'h0;
            watchdog_restart_out            <= 1'b0;
            host_mode_out                   <= 1'b0;
            charge_active_out               <= 1'b0;
            boost_active_out                <= 1'b0;
        end
        else
        begin
            high_impedance_input_enable_out <= in_q.hiz_en;
            pulse_freq_mode_disable_out     <= ctl_q.pfm_disable;
            regulate_on_bat_pin_out         <= in_q.sense_disable
                                               | remote_sense_fail_status_in;
            input_current_limit_code_out    <= in_q.ilim_code;
            input_current_limit_ma_out      <= ilim_ma;
            system_min_voltage_out          <= ctl_q.system_min_voltage;
            system_min_mv_out               <= CICR_SYSTEM_MIN_VOLTAGE_MV[ctl_q.system_min_voltage];
            boost_exit_mv_out               <= ctl_q.boost_low_sel ? CICR_BST_EXIT_LO
                                                                   : CICR_BST_EXIT_HI;
            boost_start_mv_out              <= ctl_q.boost_low_sel ? CICR_BST_START_LO
                                                                   : CICR_BST_START_HI;
            thermistor_fault_status_out     <= in_q.therm_ignore ? 3'h0
                                                                 : thermistor_fault_in;
            watchdog_restart_out            <= ctl_q.wd_kick;
            host_mode_out                   <= host_mode_q;
            charge_active_out               <= charge_go;
            boost_active_out                <= boost_go;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    chk_kick_self_clear:
    assert property (ctl_q.wd_kick && !kick_wr && !reg_reset_in |=> !ctl_q.wd_kick)
    else $error("watchdog kick bit did not clear");

    chk_kick_restart:
    assert property (kick_wr && !reg_reset_in && !wdt_expired_in
                     |=> ctl_q.wd_kick ##1 watchdog_restart_out)
    else $error("kick did not restart the watchdog");

    chk_reg_reset_all:
    assert property (reg_reset_in |=> in_q == CICR_INPUT_RST && ctl_q == CICR_CTRL_RST)
    else $error("register reset missed a field");

    chk_wdt_partial:
    assert property (wdt_expired_in && !reg_reset_in && !wr.valid && !src_detect_done_in
                     |=> !in_q.hiz_en && !ctl_q.boost_en && ctl_q.charge_en
                         && in_q.ilim_code == $past(in_q.ilim_code)
                         && ctl_q.system_min_voltage == $past(ctl_q.system_min_voltage))
    else $error("watchdog expiry restored the wrong fields");

    chk_auto_ilim:
    assert property (src_detect_done_in && !wr_input && !reg_reset_in
                     |=> in_q.ilim_code == ($past(source_select_in) ? CICR_ILIM_PSEL_HI
                                                                  : CICR_ILIM_PSEL_LO))
    else $error("automatic current limit not loaded");

    chk_host_mode:
    assert property (wr.valid && !reg_reset_in |=> ##1 host_mode_out)
    else $error("write did not enter host mode");

    chk_therm_ignore:
    assert property (in_q.therm_ignore |=> thermistor_fault_status_out == 3'h0)
    else $error("ignored thermistor still reports a fault");

    chk_charge_gate:
    assert property (charge_active_out |-> $past(charge_ok))
    else $error("charging without its enables");

    chk_ilim_scale:
    assert property (1'b1 |=> input_current_limit_ma_out
                     == 12'($past(in_q.ilim_code)) * 12'h064 + 12'h064)
    else $error("current limit scale wrong");

endmodule

`default_nettype wire

// [verif/cicr_host_model.sv]
/*
 * I2C host model for the register pair: start, stop and byte transfers.
 * Assumes SDA is open drain with a pull-up and SCL is driven only here.
 */
`timescale 1ns/1ps
`default_nettype none

module cicr_host_model
(
    input  wire logic mclk_in,
    input  wire logic sda_oe_in,
    output var logic  scl_out,
    output wire logic sda_out
);
    // ****************************************
    // wire level and bus phases
    // ****************************************
    logic sda_drv_q = 1'b1;

    initial scl_out = 1'b1;
    // pull-up wins unless the host or the device pulls low
    assign sda_out = sda_drv_q & ~sda_oe_in;

    // three clocks a phase keeps SCL above the two-clock minimum
    task automatic phase();
        repeat (3) @(negedge mclk_in);
    endtask

    task automatic put_bit(input logic b, output logic r);
        sda_drv_q = b;
        phase();
        scl_out = 1'b1;
        phase();
        r = sda_out;
        scl_out = 1'b0;
        phase();
    endtask

    // serves as first start too, since SCL and SDA idle high
    task automatic restart();
        sda_drv_q = 1'b1;
        phase();
        scl_out = 1'b1;
        phase();
        sda_drv_q = 1'b0;
        phase();
        scl_out = 1'b0;
        phase();
    endtask

    task automatic stop();
        sda_drv_q = 1'b0;
        phase();
        scl_out = 1'b1;
        phase();
        sda_drv_q = 1'b1;
        phase();
    endtask

    // msb first, ninth bit released or nack; ack returns the wire level
    task automatic byte_io(input logic [7:0] wd, input logic last,
                           output logic [7:0] rd, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(wd[i], rd[i]);
        put_bit(last, ack);
    endtask
endmodule

`default_nettype wire

// [verif/cicr_regs_test.sv]
/*
 * Self-checking bench for the charger input/control register pair.
 * Assumes the package, the design and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module cicr_regs_test
    import cicr_pkg::*;
;
    // ****************************************
    // signals, clock and instances
    // ****************************************
    localparam logic [11:0] SYS_MV [8] = '{12'ha28, 12'haf0, 12'hbb8, 12'hc80,
                                           12'hd48, 12'hdac, 12'he10, 12'he74};
    logic        mclk, rst_n, rreg, wdt, sdone, psel, ce_n, nz, adp, tgood, sfail;
    logic [2:0]  tfault, sysv, tfs;
    logic        sda_oe, sda_o, hiz, pfm, on_bat, wdr, host, chg, bst;
    logic [4:0]  code;
    logic [11:0] ma, smv, bex, bsm;
    wire         scl, sda;
    int          num_errors = 0, comparisons = 0, kicks = 0;

    initial begin mclk = 1'b0; forever #50 mclk = ~mclk; end
    always @(negedge mclk) if (wdr === 1'b1) kicks++;

    cicr_host_model cicr_host_model_i (.mclk_in(mclk), .sda_oe_in(sda_oe), .scl_out(scl),
                                       .sda_out(sda));
    cicr_regs cicr_regs_i (.mclk_in(mclk), .reset_n_in(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .reg_reset_in(rreg), .wdt_expired_in(wdt),
        .src_detect_done_in(sdone), .source_select_in(psel), .charge_pin_n_in(ce_n),
        .chg_current_nonzero_in(nz), .adapter_present_in(adp), .thermistor_good_in(tgood),
        .thermistor_fault_in(tfault), .remote_sense_fail_status_in(sfail),
        .high_impedance_input_enable_out(hiz), .pulse_freq_mode_disable_out(pfm),
        .regulate_on_bat_pin_out(on_bat), .input_current_limit_code_out(code),
        .input_current_limit_ma_out(ma), .system_min_voltage_out(sysv),
        .system_min_mv_out(smv), .boost_exit_mv_out(bex), .boost_start_mv_out(bsm),
        .thermistor_fault_status_out(tfs), .watchdog_restart_out(wdr),
        .host_mode_out(host), .charge_active_out(chg), .boost_active_out(bst));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        logic k1, k2, k3;
        cicr_host_model_i.restart();
        cicr_host_model_i.byte_io({CICR_DEV_ADDR, 1'b0}, 1'b1, x, k1);
        cicr_host_model_i.byte_io(a, 1'b1, x, k2);
        cicr_host_model_i.byte_io(d, 1'b1, x, k3);
        cicr_host_model_i.stop();
        chk(k1 | k2 | k3, 12'h000);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] x;
        logic k1, k2, k3, k4;
        cicr_host_model_i.restart();
        cicr_host_model_i.byte_io({CICR_DEV_ADDR, 1'b0}, 1'b1, x, k1);
        cicr_host_model_i.byte_io(a, 1'b1, x, k2);
        cicr_host_model_i.restart();
        cicr_host_model_i.byte_io({CICR_DEV_ADDR, 1'b1}, 1'b1, x, k3);
        cicr_host_model_i.byte_io(8'hff, 1'b1, d, k4);
        cicr_host_model_i.stop();
        chk(k1 | k2 | k3, 12'h000);
    endtask

    // 0 register reset, 1 watchdog expiry, 2 source detection done
    task automatic pulse(input int w);
        @(negedge mclk);
        case (w)
            0: rreg = 1'b1;
            1: wdt = 1'b1;
            default: sdone = 1'b1;
        endcase
        @(negedge mclk);
        {rreg, wdt, sdone} = 3'h0;
        repeat (3) @(negedge mclk);
    endtask

    task automatic gate(input logic pn, nzi, ad, tg, ec, eb);
        @(negedge mclk);
        {ce_n, nz, adp, tgood} = {pn, nzi, ad, tg};
        repeat (3) @(negedge mclk);
        chk(chg, ec);
        chk(bst, eb);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] d;
        chk(code, 12'h017);
        chk(ma, 12'h960);
        chk(smv, 12'hdac);
        chk({bex, bsm} == {12'haf0, 12'hbb8}, 12'h001);
        chk({hiz, pfm, host, sda_o}, 12'h000);
        rd(CICR_INPUT_OFS, d);
        chk(d, 12'h017);
        rd(CICR_CTRL_OFS, d);
        chk(d, 12'h01a);
        chk(host, 12'h000);
    endtask

    task automatic t_input();
        logic [7:0] d;
        wr(CICR_INPUT_OFS, 8'hc5);
        chk({hiz, host}, 12'h003);
        chk(tfs, 12'h000);
        chk(on_bat, 12'h000);
        chk(ma, 12'h258);
        sfail = 1'b1;
        repeat (3) @(negedge mclk);
        chk(on_bat, 12'h001);
        sfail = 1'b0;
        rd(CICR_INPUT_OFS, d);
        chk(d, 12'h0c5);
        wr(CICR_INPUT_OFS, 8'h3f);
        chk({tfs, on_bat, hiz}, 12'h016);
        chk(ma, 12'hc80);
    endtask

    task automatic t_control();
        logic [7:0] d;
        int k0;
        k0 = kicks;
        wr(CICR_CTRL_OFS, 8'he1);
        chk(kicks - k0, 12'h001);
        chk(pfm, 12'h001);
        chk({bex, bsm} == {12'h9c4, 12'haf0}, 12'h001);
        rd(CICR_CTRL_OFS, d);
        chk(d, 12'h0a1);
        for (int i = 0; i < 8; i++) begin
            wr(CICR_CTRL_OFS, {4'h3, i[2:0], 1'b0});
            chk(smv, SYS_MV[i]);
            chk(sysv, i[2:0]);
        end
    endtask

    task automatic t_gating();
        gate(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        gate(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        gate(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        gate(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        gate(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        wr(CICR_INPUT_OFS, 8'h7f);
        gate(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        wr(CICR_INPUT_OFS, 8'hff);
        gate(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask

    // expiry restores only hiz, kick, boost and charge; register reset restores all
    task automatic t_watchdog();
        logic [7:0] d;
        wr(CICR_INPUT_OFS, 8'hc3);
        wr(CICR_CTRL_OFS, 8'ha5);
        pulse(1);
        chk(host, 12'h000);
        rd(CICR_INPUT_OFS, d);
        chk(d, 12'h043);
        rd(CICR_CTRL_OFS, d);
        chk(d, 12'h095);
        pulse(0);
        rd(CICR_INPUT_OFS, d);
        chk(d, 12'h017);
        rd(CICR_CTRL_OFS, d);
        chk(d, 12'h01a);
    endtask

    task automatic t_srcdet();
        psel = 1'b1;
        pulse(2);
        chk(code, 12'h004);
        chk(ma, 12'h1f4);
        psel = 1'b0;
        wr(CICR_INPUT_OFS, 8'h0a);
        pulse(2);
        chk(code, 12'h017);
        chk(ma, 12'h960);
        wr(CICR_INPUT_OFS, 8'h0a);
        chk(ma, 12'h44c);
    endtask

    task automatic t_refused();
        logic [7:0] d;
        logic k1, k2;
        rd(8'h05, d);
        chk(d, CICR_UNMAPPED_RD);
        cicr_host_model_i.restart();
        cicr_host_model_i.byte_io({CICR_DEV_ADDR, 1'b0}, 1'b1, d, k1);
        cicr_host_model_i.byte_io(CICR_LAST_OFS + 8'h01, 1'b1, d, k2);
        cicr_host_model_i.stop();
        chk({k1, k2}, 12'h001);
    endtask

    task automatic summarize();
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        {rst_n, rreg, wdt, sdone, psel, ce_n, sfail, tfault} = 10'h005;
        {nz, adp, tgood} = 3'h7;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        t_reset();
        t_input();
        t_control();
        t_gating();
        t_watchdog();
        t_srcdet();
        t_refused();
        summarize();
    end

    // whole run needs about 0.8 ms of bus traffic
    initial begin
        #5000000;
        num_errors++;
        summarize();
    end
endmodule

`default_nettype wire
